//--- rtl/sna_pkg.sv
// Operation
// - Switches one to six form a binary node address, switch one the low bit, on as 1.
// - Switches seven and eight form a bit-rate code, switch seven the low bit, on as 1.
// - The switch code acts only in multidrop mode, where the point-to-point period stays; the switch address acts in both modes.
// - A switch address of zero selects the node address held in non-volatile memory.
// - A bit-rate code of zero selects the bit rate held in non-volatile memory.
// - Codes 1, 2 and 3 select 9.6, 38.4 and 115.2 kbps on the multidrop port.
// - A select input pulled to ground selects multidrop mode, otherwise point-to-point.
package sna_pkg;

    // System clock rate and period.
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_NS = 5;

    // Switch settle time after reset release, rounded up to whole cycles.
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CYC - 1);

    // Multidrop bit rates in bits per second, and their divisors in clock cycles.
    localparam int RATE_LO_BPS = 9600;
    localparam int RATE_MID_BPS = 38400;
    localparam int RATE_HI_BPS = 115200;
    localparam int DIV_LO_CYC = CLK_HZ / RATE_LO_BPS;
    localparam int DIV_MID_CYC = CLK_HZ / RATE_MID_BPS;
    localparam int DIV_HI_CYC = CLK_HZ / RATE_HI_BPS;

    // Bit-rate codes taken from switches seven and eight.
    localparam logic [1:0] CODE_NVM = 2'h0;
    localparam logic [1:0] CODE_LO = 2'h1;
    localparam logic [1:0] CODE_MID = 2'h2;
    localparam logic [1:0] CODE_HI = 2'h3;

    // Switch field positions inside the synchronised pin word.
    localparam int SW_ADDR_LSB = 0;
    localparam int SW_CODE_LSB = 6;
    localparam int SW_MD_BIT = 8;

    // Register byte offsets on the bus.
    localparam logic [7:0] REG_NVM_ADDR = 8'h00;
    localparam logic [7:0] REG_NVM_DIV = 8'h04;
    localparam logic [7:0] REG_P2P_DIV = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_ACTIVE = 8'h10;

    // Status and active register field positions.
    localparam int ST_ADDR_LSB = 0;
    localparam int ST_CODE_LSB = 6;
    localparam int ST_DONE_BIT = 8;
    localparam int ST_MD_BIT = 9;
    localparam int ST_ANVM_BIT = 10;
    localparam int ST_RNVM_BIT = 11;
    localparam int ACT_DIV_LSB = 16;

    // Values after reset, and the smallest divisor.
    localparam logic [5:0] NVM_ADDR_RST = 6'h01;
    localparam logic [15:0] NVM_DIV_RST = 16'h5161;
    localparam logic [15:0] P2P_DIV_RST = 16'h5161;
    localparam logic [15:0] DIV_MIN = 16'h0002;

    // Capture sequencer states.
    typedef enum logic {CAP_SETTLE, CAP_HOLD} sna_cap_t;

    // Merges write data into an old word under the byte enables.
    function automatic logic [31:0] sna_lane_merge(input logic [31:0] old_w,
                                                   input logic [31:0] new_w,
                                                   input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Keeps a divisor at two or more so the tick stays a single pulse.
    function automatic logic [15:0] sna_div_guard(input logic [15:0] d);
        return (d < DIV_MIN) ? DIV_MIN : d;
    endfunction

endpackage

//--- rtl/sna_sync.sv
module sna_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic [W-1:0] d, // Asynchronous input word.
    output logic [W-1:0] q // Synchronised word.
);

    logic [W-1:0] meta_r;

    // Two flip-flops in a row; only the second stage is read outside.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // sna_sync

//--- rtl/sna_top.sv
// Our own choices: the Wishbone register port and the register offsets.
module sna_top #(
    parameter logic [15:0] DIV_LO = 16'(sna_pkg::DIV_LO_CYC),
    parameter logic [15:0] DIV_MID = 16'(sna_pkg::DIV_MID_CYC),
    parameter logic [15:0] DIV_HI = 16'(sna_pkg::DIV_HI_CYC)
) (
    input wire logic clk_sys, // System clock, 200 MHz.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic [7:0] sw_pin, // Setting switches, on reads 1.
    input wire logic sel_n_pin, // Interface select, low picks multidrop.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Bus strobe.
    input wire logic wb_we_i, // Write enable.
    input wire logic [7:0] wb_adr_i, // Byte address.
    input wire logic [3:0] wb_sel_i, // Byte enables.
    input wire logic [31:0] wb_dat_i, // Write data.
    output logic [31:0] wb_dat_o, // Read data.
    output logic wb_ack_o, // Acknowledge.
    output logic md_mode_o, // High in multidrop mode.
    output logic [5:0] node_addr_o, // Effective multidrop node address.
    output logic [15:0] bit_div_o, // Effective bit period in clock cycles.
    output logic baud_tick_o, // One-cycle pulse per bit period.
    output logic cfg_done_o // High once the switches are captured.
);
    import sna_pkg::*;

    logic [8:0] pin_q;
    logic [5:0] nvm_addr_r;
    logic [5:0] nvm_addr_nxt;
    logic [15:0] nvm_div_r;
    logic [15:0] nvm_div_nxt;
    logic [15:0] p2p_div_r;
    logic [15:0] p2p_div_nxt;
    logic [5:0] sw_addr_r;
    logic [1:0] sw_code_r;
    sna_cap_t cap_r;
    logic [4:0] settle_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic md_r;
    logic [5:0] addr_r;
    logic [15:0] div_r;
    logic [15:0] cnt_r;
    logic tick_r;

    // The select pin is inverted ahead of the synchroniser so a high word bit means multidrop.
    sna_sync #(
        .W(9)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d({~sel_n_pin, sw_pin}),
        .q(pin_q)
    );

    // Capture sequencer: wait for the switches to settle, then take them once.
    wire settle_done = (cap_r == CAP_SETTLE) && (settle_r == SETTLE_LAST);
    wire cap_fire = settle_done;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cap_r <= CAP_SETTLE;
            settle_r <= 5'h00;
        end else begin
            unique case (cap_r)
                CAP_SETTLE: begin
                    settle_r <= settle_r + 5'h01;
                    if (settle_done) begin
                        cap_r <= CAP_HOLD;
                    end
                end
                CAP_HOLD: begin
                    settle_r <= settle_r;
                end
            endcase
        end
    end

    // Switch fields: one to six give the address, seven and eight the rate code.
    wire [5:0] pin_addr = pin_q[SW_ADDR_LSB +: 6];
    wire [1:0] pin_code = pin_q[SW_CODE_LSB +: 2];

    // Captured switch values stay frozen until the next reset.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sw_addr_r <= 6'h00;
            sw_code_r <= 2'h0;
        end else if (cap_fire) begin
            sw_addr_r <= pin_addr;
            sw_code_r <= pin_code;
        end
    end

    assign cfg_done_o = (cap_r == CAP_HOLD);

    // Bus decode; a request is taken once, in the cycle before the acknowledge.
    // A write lands on the edge at which the master samples the acknowledge, while it still holds.
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    wire hit_nvm_addr = (wb_adr_i == REG_NVM_ADDR);
    wire hit_nvm_div = (wb_adr_i == REG_NVM_DIV);
    wire hit_p2p_div = (wb_adr_i == REG_P2P_DIV);
    wire hit_status = (wb_adr_i == REG_STATUS);
    wire hit_active = (wb_adr_i == REG_ACTIVE);

    // Write data merged under the byte enables for each writable register.
    wire [31:0] m_nvm_addr = sna_lane_merge({26'h0, nvm_addr_r}, wb_dat_i, wb_sel_i);
    wire [31:0] m_nvm_div = sna_lane_merge({16'h0, nvm_div_r}, wb_dat_i, wb_sel_i);
    wire [31:0] m_p2p_div = sna_lane_merge({16'h0, p2p_div_r}, wb_dat_i, wb_sel_i);

    assign nvm_addr_nxt = (bus_wr && hit_nvm_addr) ? m_nvm_addr[5:0] : nvm_addr_r;
    assign nvm_div_nxt = (bus_wr && hit_nvm_div) ? m_nvm_div[15:0] : nvm_div_r;
    assign p2p_div_nxt = (bus_wr && hit_p2p_div) ? m_p2p_div[15:0] : p2p_div_r;

    // Stored settings that software loads from non-volatile memory.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            nvm_addr_r <= NVM_ADDR_RST;
            nvm_div_r <= NVM_DIV_RST;
            p2p_div_r <= P2P_DIV_RST;
        end else begin
            nvm_addr_r <= nvm_addr_nxt;
            nvm_div_r <= nvm_div_nxt;
            p2p_div_r <= p2p_div_nxt;
        end
    end

    // Status words; unmapped addresses read as zero.
    wire addr_nvm = (sw_addr_r == 6'h00);
    wire rate_nvm = (sw_code_r == CODE_NVM);
    wire [31:0] status_w = {20'h0, rate_nvm, addr_nvm, md_r, cfg_done_o, sw_code_r, sw_addr_r};
    wire [31:0] active_w = {div_r, 10'h0, addr_r};
    wire [31:0] rd_w = hit_nvm_addr ? {26'h0, nvm_addr_r} :
                       hit_nvm_div ? {16'h0, nvm_div_r} :
                       hit_p2p_div ? {16'h0, p2p_div_r} :
                       hit_status ? status_w :
                       hit_active ? active_w : 32'h0;

    // Acknowledge one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r <= bus_req;
            if (bus_req && !wb_we_i) begin
                rdat_r <= rd_w;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Selection of address and bit period from switches or stored values.
    wire [5:0] md_addr = addr_nvm ? nvm_addr_r : sw_addr_r;
    wire [15:0] md_div = (sw_code_r == CODE_LO) ? DIV_LO :
                         (sw_code_r == CODE_MID) ? DIV_MID :
                         (sw_code_r == CODE_HI) ? DIV_HI :
                         nvm_div_r;
    wire md_now = pin_q[SW_MD_BIT];
    wire [15:0] eff_div = md_r ? md_div : p2p_div_r;

    // Registered outputs of the selection.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            md_r <= 1'b0;
            addr_r <= NVM_ADDR_RST;
            div_r <= P2P_DIV_RST;
        end else begin
            md_r <= md_now;
            addr_r <= md_addr;
            div_r <= sna_div_guard(eff_div);
        end
    end

    assign md_mode_o = md_r;
    assign node_addr_o = addr_r;
    assign bit_div_o = div_r;

    // Bit-rate divider; a shortened period restarts cleanly through the compare.
    wire cnt_wrap = (cnt_r >= div_r - 16'h0001);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_wrap ? 16'h0000 : cnt_r + 16'h0001;
            tick_r <= cnt_wrap;
        end
    end

    assign baud_tick_o = tick_r;

    // Checker helpers: cycles since the last tick and the bit period seen at that tick.
    // A period change between two ticks clears the steady flag, so that gap is not judged.
    logic [15:0] gap_r;
    logic [15:0] div_ref_r;
    logic steady_r;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            gap_r <= 16'h0000;
            div_ref_r <= 16'h0000;
            steady_r <= 1'b0;
        end else if (baud_tick_o) begin
            gap_r <= 16'h0001;
            div_ref_r <= bit_div_o;
            steady_r <= 1'b1;
        end else begin
            gap_r <= gap_r + 16'h0001;
            steady_r <= steady_r && (bit_div_o == div_ref_r);
        end
    end

    // Checks of the intended behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_hold_two;
        cfg_done_o ##1 cfg_done_o;
    endsequence

    sequence s_tick_steady;
        baud_tick_o && steady_r && (bit_div_o == div_ref_r);
    endsequence

    sequence s_wr_addr_ack;
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && hit_nvm_addr && wb_sel_i[0];
    endsequence

    AST_ADDR_MAP: assert property (cap_fire |=> sw_addr_r == $past(pin_q[5:0]))
        else $error("Switch address not taken from switches one to six.");

    AST_CODE_MAP: assert property (cap_fire |=> sw_code_r == $past(pin_q[7:6]))
        else $error("Rate code not taken from switches seven and eight.");

    AST_P2P_KEEP: assert property (!md_r |=> bit_div_o == sna_div_guard($past(p2p_div_r)))
        else $error("Point-to-point bit period disturbed by the switches.");

    AST_ADDR_NVM: assert property (addr_nvm |=> node_addr_o == $past(nvm_addr_r))
        else $error("Zero switch address did not pick the stored address.");

    AST_ADDR_SW: assert property (!addr_nvm |=> node_addr_o == $past(sw_addr_r))
        else $error("Nonzero switch address not used.");

    AST_RATE_NVM: assert property (md_r && rate_nvm |=>
                                   bit_div_o == sna_div_guard($past(nvm_div_r)))
        else $error("Zero rate code did not pick the stored bit period.");

    AST_RATE_LO: assert property (md_r && sw_code_r == CODE_LO |=> bit_div_o == DIV_LO)
        else $error("Code 1 did not select the 9.6 kbps period.");

    AST_RATE_HI: assert property (md_r && sw_code_r == CODE_HI |=> bit_div_o == DIV_HI)
        else $error("Code 3 did not select the 115.2 kbps period.");

    AST_MODE_SEL: assert property (pin_q[8] |=> md_mode_o ##1 1'b1)
        else $error("Grounded select did not give multidrop mode.");

    AST_HOLD: assert property (s_hold_two |-> $stable(sw_addr_r) && $stable(sw_code_r))
        else $error("Captured switch values changed after capture.");

    AST_CAP_TIME: assert property ($rose(cfg_done_o) |-> $past(settle_r) == SETTLE_LAST)
        else $error("Switches captured before the settle time ran out.");

    AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse)
        else $error("Bus acknowledge is not a one-cycle pulse after the request.");

    AST_TICK: assert property (baud_tick_o |=> !baud_tick_o)
        else $error("Bit tick lasted more than one cycle.");

    AST_TICK_GAP: assert property (s_tick_steady |-> gap_r == bit_div_o)
        else $error("Bit ticks are not one bit period apart.");

    AST_RATE_MID: assert property (md_r && sw_code_r == CODE_MID |=>
                                   bit_div_o == DIV_MID)
        else $error("Code 2 did not select the 38.4 kbps period.");

    AST_MODE_P2P: assert property (!pin_q[SW_MD_BIT] |=> !md_mode_o)
        else $error("Open select did not give point-to-point mode.");

    AST_DONE_STAY: assert property (cfg_done_o |=> cfg_done_o)
        else $error("Capture done dropped before the next reset.");

    AST_CAP_ONCE: assert property (cfg_done_o |-> !cap_fire)
        else $error("Switches captured a second time.");

    AST_SETTLE_STEP: assert property (resetn && cap_r == CAP_SETTLE && !settle_done |=>
                                      settle_r == $past(settle_r) + 5'h01)
        else $error("Settle counter skipped a step.");

    AST_WB_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("Bus acknowledge without a request.");

    AST_WB_RDAT: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("Read data changed outside a read acknowledge.");

    AST_WB_WRITE: assert property (s_wr_addr_ack |=> nvm_addr_r == $past(wb_dat_i[5:0]))
        else $error("Stored address write did not land on the acknowledge edge.");

endmodule // sna_top

//--- sim/sna_host_model.sv
module sna_host_model (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic baud_tick, // Bit period pulse from the drive.
    output logic [15:0] period_cyc // Last measured bit period in cycles.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] count_r;
    // Measures the spacing of ticks as the host's bit timer would see it.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            count_r <= 16'h0000;
            period_cyc <= 16'h0000;
        end else if (baud_tick) begin
            period_cyc <= count_r + 16'h0001;
            count_r <= 16'h0000;
        end else begin
            count_r <= count_r + 16'h0001;
        end
    end
endmodule // sna_host_model

//--- sim/testbench.sv
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sna_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, sel_n_pin = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] sw_pin = 8'h00, wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0, sel_v = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, md_mode_o, baud_tick_o, cfg_done_o;
    logic [5:0] node_addr_o;
    logic [15:0] bit_div_o, period_cyc;
    logic [5:0] addr_t [4] = '{6'h00, 6'h21, 6'h3e, 6'h01};
    logic [15:0] div_t [4] = '{16'h5161, 16'h0008, 16'h0006, 16'h0004};
    int err_count = 0, samples_checked = 0;
    always #2.5 clk_sys = ~clk_sys;
    // Design under test with shortened bit periods.
    sna_top #(.DIV_LO(16'h0008), .DIV_MID(16'h0006), .DIV_HI(16'h0004)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .sw_pin(sw_pin), .sel_n_pin(sel_n_pin),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .md_mode_o(md_mode_o), .node_addr_o(node_addr_o), .bit_div_o(bit_div_o),
        .baud_tick_o(baud_tick_o), .cfg_done_o(cfg_done_o));
    // Host side timer that watches the bit ticks.
    sna_host_model host (.clk_sys(clk_sys), .resetn(resetn), .baud_tick(baud_tick_o),
        .period_cyc(period_cyc));
    // Prints the verdict and stops the run.
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One classic bus cycle, held until ack is sampled high; only the watchdog ends a hang.
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel_v;
        wb_dat_i <= dat;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Resets with the given switches and waits for their capture.
    task automatic reset_dut(input logic [7:0] sw, input logic sel);
        @(posedge clk_sys);
        resetn <= 1'b0;
        sw_pin <= sw;
        sel_n_pin <= sel;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (10) @(posedge clk_sys);
        `CHK(cfg_done_o, 1'b0)
        repeat (16) @(posedge clk_sys);
        `CHK(cfg_done_o, 1'b1)
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        end_of_test();
    end
    initial begin
        reset_dut(8'h00, 1'b0);
        wb_xfer(1'b0, REG_NVM_ADDR, 32'h0);
        `CHK(rd, 32'h00000001)
        wb_xfer(1'b0, REG_NVM_DIV, 32'h0);
        `CHK(rd, 32'h00005161)
        wb_xfer(1'b0, REG_P2P_DIV, 32'h0);
        `CHK(rd, 32'h00005161)
        wb_xfer(1'b1, REG_STATUS, 32'hffffffff);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        `CHK(rd, 32'h00000f00)
        wb_xfer(1'b0, 8'h14, 32'h0);
        `CHK(rd, 32'h00000000)
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            reset_dut({i[1:0], addr_t[i]}, 1'b0);
            `CHK(md_mode_o, 1'b1)
            `CHK(node_addr_o, (i == 0) ? 6'h01 : addr_t[i])
            `CHK(bit_div_o, div_t[i])
            wb_xfer(1'b0, REG_STATUS, 32'h0);
            `CHK(rd, {20'h0, i == 0, i == 0, 2'b11, i[1:0], addr_t[i]})
        end
        $display("test switch codes done");
        reset_dut(8'h00, 1'b0);
        wb_xfer(1'b1, REG_NVM_ADDR, 32'h00000005);
        wb_xfer(1'b1, REG_NVM_DIV, 32'h00000007);
        repeat (40) @(posedge clk_sys);
        `CHK(node_addr_o, 6'h05)
        `CHK(bit_div_o, 16'h0007)
        `CHK(period_cyc, 16'h0007)
        wb_xfer(1'b1, REG_NVM_DIV, 32'h00000001);
        repeat (3) @(posedge clk_sys);
        `CHK(bit_div_o, 16'h0002)
        sel_v = 4'h2;
        wb_xfer(1'b1, REG_NVM_DIV, 32'h0000ab00);
        sel_v = 4'hf;
        wb_xfer(1'b0, REG_NVM_DIV, 32'h0);
        `CHK(rd, 32'h0000ab01)
        $display("test stored values done");
        reset_dut(8'h95, 1'b0);
        sw_pin <= 8'hff;
        repeat (10) @(posedge clk_sys);
        `CHK(node_addr_o, 6'h15)
        `CHK(bit_div_o, 16'h0006)
        sel_n_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK(md_mode_o, 1'b0)
        `CHK(bit_div_o, 16'h5161)
        wb_xfer(1'b1, REG_P2P_DIV, 32'h00000009);
        repeat (40) @(posedge clk_sys);
        `CHK(bit_div_o, 16'h0009)
        `CHK(period_cyc, 16'h0009)
        wb_xfer(1'b0, REG_ACTIVE, 32'h0);
        `CHK(rd, 32'h00090015)
        sel_n_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHK(md_mode_o, 1'b1)
        `CHK(bit_div_o, 16'h0006)
        $display("test hold and mode done");
        end_of_test();
    end
endmodule // testbench
